// [rtl/crf_top.sv]
// CPU programmer-visible register file with an AXI4-Lite command port
// Function
// - Eight-bit accumulator holds operands and receives ALU results.
// - Sixteen-bit index register is high byte concatenated with low byte.
// - Indexed address comes from index; index also stores data.
// - Sixteen-bit stack pointer points at next free slot; reset to 00ff.
// - Stack low reset sets pointer low byte to ff, keeps high.
// - Push decrements stack pointer per byte; pull increments it.
// - Stack addressing forms address as stack pointer plus offset.
// - Program counter increments on fetch; jumps and interrupts load it.
// - Reset loads program counter from vector at fffe and ffff.
// - Flag register holds mask and five flags; bits 6,5 read one.
// - Overflow flag set on two's complement overflow, else cleared.
// - Half carry set on carry from bit 3 into 4 on adds.
// - Decimal adjust picks correction from half carry and carry.
// - Mask set blocks maskable interrupts; clear accepts them.
// - Interrupt entry sets mask after stacking, before vector fetch.
// - Interrupt entry does not push index high byte.
// - With mask clear, highest priority pending request is serviced.
// - Interrupt return restores stacked registers including mask.
// - Reset sets mask; mask clear or sleep clears it; return reloads it.
// - Negative flag equals result bit 7.
// - Zero flag set when result is 00, else cleared.
// - Carry on add carry out, subtract borrow, and shifts.
// - Sleep instructions clear mask; reset exit leaves it set.
`timescale 1ns/10ps
`include "crf_regs.svh"
module crf_top (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [7:0]  memData,
  input  wire logic [3:0]  irqPending,
  output logic [15:0]      busAddr,
  output logic [15:0]      operandAddr,
  output logic [7:0]       pushData,
  output logic             pushStrobe,
  output logic             irqTaken,
  output logic [1:0]       irqLevel,
  output logic             sleeping
);
  // ==========================================================
  // Register state
  logic [7:0]  acc;
  logic [7:0]  indexHigh;
  logic [7:0]  indexLow;
  logic [15:0] stackPointer;
  logic [15:0] programCounter;
  logic [7:0]  flagRegister;
  crf_pkg::crf_state_e state;
  logic [15:0] operand;
  logic [31:0] cmdWord;
  logic        cmdGo;
  logic [7:0]  opA;
  logic [7:0]  res;
  logic [8:0]  sum;
  logic        halfCarry;
  logic        overflow;
  logic        carry;
  logic [7:0]  adjust;
  logic        irqAny;
  logic [1:0]  irqSel;
  logic [15:0] indexFull;
  crf_pkg::crf_op_e op;
  crf_pkg::crf_pull_s pulled;

  assign op = crf_pkg::crf_op_e'(cmdWord[3:0]);
  assign indexFull = {indexHigh, indexLow};
  assign pulled = crf_pkg::crf_pull_s'(operand);

  // ==========================================================
  // AXI4-Lite slave
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        wrFire;

  assign wrFire = awHeld && wHeld && !s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CRF_RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !wHeld && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (wrFire) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awAddr == `CRF_ADDR_CMD ||
                        awAddr == `CRF_ADDR_OPER) ?
                       `CRF_RESP_OKAY : `CRF_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Command word; writing it launches one instruction step
  always_ff @(posedge clk) begin
    if (rst) begin
      cmdWord <= 32'h0000_0000;
      operand <= 16'h0000;
      cmdGo <= 1'b0;
    end else begin
      cmdGo <= wrFire && awAddr == `CRF_ADDR_CMD;
      if (wrFire && awAddr == `CRF_ADDR_CMD) begin
        cmdWord <= wData;
      end
      if (wrFire && awAddr == `CRF_ADDR_OPER) begin
        if (wStrb[0]) operand[7:0] <= wData[7:0];
        if (wStrb[1]) operand[15:8] <= wData[15:8];
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CRF_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `CRF_RESP_OKAY;
        unique case (s_axi_araddr)
          `CRF_ADDR_ACC:    s_axi_rdata <= {24'h000000, acc};
          `CRF_ADDR_INDEX:  s_axi_rdata <= {16'h0000, indexFull};
          `CRF_ADDR_STACK:  s_axi_rdata <= {16'h0000, stackPointer};
          `CRF_ADDR_PROG:   s_axi_rdata <= {16'h0000, programCounter};
          `CRF_ADDR_FLAGS:  s_axi_rdata <= {24'h000000, flagRegister};
          `CRF_ADDR_CMD:    s_axi_rdata <= cmdWord;
          `CRF_ADDR_OPER:   s_axi_rdata <= {16'h0000, operand};
          `CRF_ADDR_STATUS: s_axi_rdata <= {29'h00000000,
                                            sleeping, state};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CRF_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // ALU results feeding the flags
  assign opA = operand[7:0];
  always_comb begin
    sum = 9'h000;
    halfCarry = 1'b0;
    overflow = 1'b0;
    carry = flagRegister[`CRF_BIT_C];
    adjust = `CRF_ZERO8;
    res = acc;
    unique case (op)
      crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC: begin
        sum = {1'b0, acc} + {1'b0, opA} +
              {8'h00, op == crf_pkg::CRF_OP_ADC &&
                      flagRegister[`CRF_BIT_C]};
        halfCarry = sum[4] ^ acc[4] ^ opA[4];
        overflow = (acc[7] == opA[7]) && (sum[7] != acc[7]);
        carry = sum[8];
        res = sum[7:0];
      end
      crf_pkg::CRF_OP_SUB: begin
        sum = {1'b0, acc} - {1'b0, opA};
        overflow = (acc[7] != opA[7]) && (sum[7] != acc[7]);
        carry = sum[8];
        res = sum[7:0];
      end
      crf_pkg::CRF_OP_AND: res = acc & opA;
      crf_pkg::CRF_OP_SHL: begin
        res = {acc[6:0], 1'b0};
        carry = acc[7];
        overflow = acc[7] ^ acc[6];
      end
      crf_pkg::CRF_OP_DECADJ: begin
        // Correction chosen from half carry and carry
        if (flagRegister[`CRF_BIT_H] || acc[3:0] > 4'h9) adjust[3:0] = 4'h6;
        if (flagRegister[`CRF_BIT_C] || acc > 8'h99) begin
          adjust[7:4] = 4'h6;
          carry = 1'b1;
        end
        res = acc + adjust;
      end
      default: res = acc;
    endcase
  end

  // Fixed priority: lowest index wins
  always_comb begin
    irqSel = 2'd0;
    for (int i = 3; i >= 0; i--) begin
      if (irqPending[i]) irqSel = 2'(i);
    end
  end
  assign irqAny = |irqPending && !flagRegister[`CRF_BIT_I];

  // ==========================================================
  // Reset vector sequence then instruction steps
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= crf_pkg::CRF_ST_VECHI;
      busAddr <= `CRF_VEC_RESET_HI;
    end else begin
      unique case (state)
        crf_pkg::CRF_ST_VECHI: begin
          state <= crf_pkg::CRF_ST_VECLO;
          busAddr <= `CRF_VEC_RESET_LO;
        end
        crf_pkg::CRF_ST_VECLO: begin
          state <= crf_pkg::CRF_ST_RUN;
          busAddr <= programCounter;
        end
        crf_pkg::CRF_ST_RUN: busAddr <= programCounter;
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      programCounter <= 16'h0000;
    end else if (state == crf_pkg::CRF_ST_VECHI) begin
      programCounter[15:8] <= memData;
    end else if (state == crf_pkg::CRF_ST_VECLO) begin
      programCounter[7:0] <= memData;
    end else if (cmdGo) begin
      if (op == crf_pkg::CRF_OP_JUMP || op == crf_pkg::CRF_OP_IRQ) begin
        programCounter <= operand;
      end else if (op == crf_pkg::CRF_OP_FETCH) begin
        programCounter <= programCounter + `CRF_ONE16;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      stackPointer <= `CRF_SP_RESET;
    end else if (cmdGo && state == crf_pkg::CRF_ST_RUN) begin
      unique case (op)
        crf_pkg::CRF_OP_SPLOW: stackPointer[7:0] <= `CRF_SP_LOW_RESET;
        crf_pkg::CRF_OP_PUSH, crf_pkg::CRF_OP_IRQ:
          stackPointer <= stackPointer - `CRF_ONE16;
        crf_pkg::CRF_OP_PULL, crf_pkg::CRF_OP_IRET:
          stackPointer <= stackPointer + `CRF_ONE16;
        default: stackPointer <= stackPointer;
      endcase
    end
  end
  // Interrupt entry stacks flags only; index high is left alone
  always_ff @(posedge clk) begin
    if (rst) begin
      acc <= `CRF_ZERO8;
      indexHigh <= `CRF_ZERO8;
      indexLow <= `CRF_ZERO8;
      pushData <= `CRF_ZERO8;
      pushStrobe <= 1'b0;
      operandAddr <= 16'h0000;
    end else begin
      pushStrobe <= 1'b0;
      if (cmdGo && state == crf_pkg::CRF_ST_RUN) begin
        // Bit 4 selects stack base, else index base
        operandAddr <= (cmdWord[4] ? stackPointer : indexFull) + operand;
        unique case (op)
          crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC, crf_pkg::CRF_OP_SUB,
          crf_pkg::CRF_OP_AND, crf_pkg::CRF_OP_SHL,
          crf_pkg::CRF_OP_DECADJ: acc <= res;
          crf_pkg::CRF_OP_PUSH: begin
            pushData <= cmdWord[5] ? indexHigh : acc;
            pushStrobe <= 1'b1;
          end
          crf_pkg::CRF_OP_PULL: begin
            if (cmdWord[5]) indexHigh <= pulled.flags;
            else {indexHigh, indexLow} <= operand;
          end
          crf_pkg::CRF_OP_IRQ: begin
            pushData <= flagRegister;
            pushStrobe <= 1'b1;
          end
          default: acc <= acc;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flagRegister <= `CRF_FLAG_RESET | (8'h01 << `CRF_BIT_I);
      irqTaken <= 1'b0;
      irqLevel <= 2'd0;
      sleeping <= 1'b0;
    end else begin
      irqTaken <= 1'b0;
      if (sleeping && irqAny) sleeping <= 1'b0;
      if (cmdGo && state == crf_pkg::CRF_ST_RUN) begin
        unique case (op)
          crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADC, crf_pkg::CRF_OP_SUB,
          crf_pkg::CRF_OP_SHL, crf_pkg::CRF_OP_AND,
          crf_pkg::CRF_OP_DECADJ: begin
            flagRegister[`CRF_BIT_V] <= op == crf_pkg::CRF_OP_AND ?
                                        1'b0 : overflow;
            if (op == crf_pkg::CRF_OP_ADD || op == crf_pkg::CRF_OP_ADC)
              flagRegister[`CRF_BIT_H] <= halfCarry;
            flagRegister[`CRF_BIT_N] <= res[7];
            flagRegister[`CRF_BIT_Z] <= res == `CRF_ZERO8;
            if (op != crf_pkg::CRF_OP_AND)
              flagRegister[`CRF_BIT_C] <= carry;
          end
          crf_pkg::CRF_OP_CLRMASK: flagRegister[`CRF_BIT_I] <= 1'b0;
          crf_pkg::CRF_OP_IRQ: begin
            // Mask set in the same step that stacks, before vector use
            flagRegister[`CRF_BIT_I] <= 1'b1;
            irqTaken <= irqAny;
            irqLevel <= irqSel;
          end
          crf_pkg::CRF_OP_IRET: begin
            flagRegister <= pulled.index | `CRF_FLAG_RESET;
          end
          crf_pkg::CRF_OP_SLEEP: begin
            flagRegister[`CRF_BIT_I] <= 1'b0;
            sleeping <= 1'b1;
          end
          default: flagRegister <= flagRegister;
        endcase
      end
    end
  end

  // ==========================================================
  // Checks
  chk_sp_reset: assert property (@(posedge clk)
    $past(rst) |-> stackPointer == `CRF_SP_RESET)
    else $error("stack pointer not preset");
  chk_mask_reset: assert property (@(posedge clk)
    $past(rst) |-> flagRegister[`CRF_BIT_I])
    else $error("mask not set at reset");
  chk_fixed_ones: assert property (@(posedge clk) disable iff (rst)
    flagRegister[`CRF_BIT_ONE6] && flagRegister[`CRF_BIT_ONE5])
    else $error("fixed ones lost");
  chk_push_dec: assert property (@(posedge clk) disable iff (rst)
    cmdGo && op == crf_pkg::CRF_OP_PUSH && state == crf_pkg::CRF_ST_RUN
    |=> stackPointer == $past(stackPointer) - `CRF_ONE16)
    else $error("push did not decrement");
  chk_splow: assert property (@(posedge clk) disable iff (rst)
    cmdGo && op == crf_pkg::CRF_OP_SPLOW && state == crf_pkg::CRF_ST_RUN
    |=> stackPointer == {$past(stackPointer[15:8]), `CRF_SP_LOW_RESET})
    else $error("stack low reset wrong");
  sequence seqIrqEntry;
    cmdGo && op == crf_pkg::CRF_OP_IRQ && state == crf_pkg::CRF_ST_RUN;
  endsequence
  chk_irq_mask: assert property (@(posedge clk) disable iff (rst)
    seqIrqEntry |=> flagRegister[`CRF_BIT_I] && pushStrobe)
    else $error("interrupt entry mask");
  chk_zero_flag: assert property (@(posedge clk) disable iff (rst)
    cmdGo && op == crf_pkg::CRF_OP_AND && state == crf_pkg::CRF_ST_RUN
    |=> flagRegister[`CRF_BIT_Z] == (acc == `CRF_ZERO8))
    else $error("zero flag wrong");
  chk_vector: assert property (@(posedge clk) disable iff (rst)
    state == crf_pkg::CRF_ST_VECLO ##1 state == crf_pkg::CRF_ST_RUN
    |-> programCounter[7:0] == $past(memData))
    else $error("vector load wrong");
endmodule : crf_top

// [rtl/crf_regs.svh]
// Constants for the CPU register file: reset values, flag positions, codes
`ifndef CRF_REGS_SVH
`define CRF_REGS_SVH
`define CRF_SP_RESET     16'h00ff
`define CRF_SP_LOW_RESET 8'hff
`define CRF_FLAG_RESET   8'h60
`define CRF_BIT_V        7
`define CRF_BIT_ONE6     6
`define CRF_BIT_ONE5     5
`define CRF_BIT_H        4
`define CRF_BIT_I        3
`define CRF_BIT_N        2
`define CRF_BIT_Z        1
`define CRF_BIT_C        0
`define CRF_VEC_RESET_HI 16'hfffe
`define CRF_VEC_RESET_LO 16'hffff
`define CRF_ZERO8        8'h00
`define CRF_ONE16        16'h0001
// AXI4-Lite byte addresses (word per register)
`define CRF_ADDR_ACC     8'h00
`define CRF_ADDR_INDEX   8'h04
`define CRF_ADDR_STACK   8'h08
`define CRF_ADDR_PROG    8'h0c
`define CRF_ADDR_FLAGS   8'h10
`define CRF_ADDR_CMD     8'h14
`define CRF_ADDR_OPER    8'h18
`define CRF_ADDR_STATUS  8'h1c
`define CRF_RESP_OKAY    2'b00
`define CRF_RESP_SLVERR  2'b10
`endif

// [rtl/crf_pkg.sv]
// Types shared by the CPU register file
package crf_pkg;
  typedef enum logic [3:0] {
    CRF_OP_NOP     = 4'b0000,
    CRF_OP_ADD     = 4'b0001,
    CRF_OP_ADC     = 4'b0010,
    CRF_OP_SUB     = 4'b0011,
    CRF_OP_AND     = 4'b0100,
    CRF_OP_SHL     = 4'b0101,
    CRF_OP_DECADJ  = 4'b0110,
    CRF_OP_PUSH    = 4'b0111,
    CRF_OP_PULL    = 4'b1000,
    CRF_OP_SPLOW   = 4'b1001,
    CRF_OP_CLRMASK = 4'b1010,
    CRF_OP_IRQ     = 4'b1011,
    CRF_OP_IRET    = 4'b1100,
    CRF_OP_JUMP    = 4'b1101,
    CRF_OP_FETCH   = 4'b1110,
    CRF_OP_SLEEP   = 4'b1111
  } crf_op_e;
  typedef enum logic [1:0] {
    CRF_ST_VECHI = 2'b00,
    CRF_ST_VECLO = 2'b01,
    CRF_ST_RUN   = 2'b10
  } crf_state_e;
  typedef struct packed {
    logic [7:0] index;
    logic [7:0] flags;
  } crf_pull_s;
endpackage : crf_pkg

// [dv/crf_tb.sv]
// Self-checking bench for the CPU register file over its AXI4-Lite port
`timescale 1ns/10ps
`include "crf_regs.svh"
module tb;
  // ==========================================
  // Signals
  logic        clk, rst, awValid, wValid, bReady, arValid, rReady;
  logic [7:0]  awAddr, arAddr, memData, pushData, lastPush;
  logic [31:0] wData, rData, rd;
  logic [3:0]  wStrb, irqPending;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp, irqLevel, lastLevel, resp;
  logic [15:0] busAddr, operandAddr;
  logic        pushStrobe, irqTaken, sleeping;
  int          err_count, total_checks, pushCount, irqCount, n, p0, q0;

  crf_top DUT (
    .clk(clk), .rst(rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady), .memData(memData),
    .irqPending(irqPending), .busAddr(busAddr), .operandAddr(operandAddr),
    .pushData(pushData), .pushStrobe(pushStrobe), .irqTaken(irqTaken),
    .irqLevel(irqLevel), .sleeping(sleeping)
  );

  // ==========================================
  // Memory model and monitors
  // Memory answers in the same cycle, so the vector is seen while addressed
  assign memData = (busAddr == `CRF_VEC_RESET_HI) ? 8'ha5 :
                   (busAddr == `CRF_VEC_RESET_LO) ? 8'h3c : 8'h00;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (pushStrobe === 1'b1) begin
      pushCount++;
      lastPush = pushData;
    end
    if (irqTaken === 1'b1) begin
      irqCount++;
      lastLevel = irqLevel;
    end
  end

  // ==========================================
  // Tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    awAddr  <= a;
    wData   <= d;
    awValid <= 1'b1;
    wValid  <= 1'b1;
    bReady  <= 1'b1;
    forever begin
      @(posedge clk);
      if (awValid && awReady) awValid <= 1'b0;
      if (wValid && wReady) wValid <= 1'b0;
      if (bValid === 1'b1) break;
    end
    resp = bResp;
    bReady <= 1'b0;
    @(posedge clk);
  endtask : axiWr

  task automatic axiRd(input logic [7:0] a);
    arAddr  <= a;
    arValid <= 1'b1;
    rReady  <= 1'b1;
    forever begin
      @(posedge clk);
      if (arValid && arReady) arValid <= 1'b0;
      if (rValid === 1'b1) break;
    end
    rd = rData;
    resp = rResp;
    rReady <= 1'b0;
    @(posedge clk);
  endtask : axiRd

  task automatic rdChk(input logic [7:0] a, input logic [15:0] exp,
                       input logic [15:0] m);
    axiRd(a);
    check(rd[15:0] & m, exp & m);
  endtask : rdChk

  // Operand first: the command write triggers execution
  task automatic doCmd(input crf_pkg::crf_op_e op, input logic [1:0] sel,
                       input logic [15:0] v);
    axiWr(`CRF_ADDR_OPER, {16'h0, v});
    axiWr(`CRF_ADDR_CMD, {26'h0, sel, op});
    repeat (2) @(posedge clk);
  endtask : doCmd

  task automatic alu(input crf_pkg::crf_op_e op, input logic [7:0] v,
                     input logic [7:0] a, input logic [7:0] f,
                     input logic [7:0] m);
    doCmd(op, 2'b00, {8'h0, v});
    rdChk(`CRF_ADDR_ACC, {8'h0, a}, 16'h00ff);
    rdChk(`CRF_ADDR_FLAGS, {8'h0, f}, {8'h0, m});
  endtask : alu

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #100000;
    err_count++;
    give_verdict();
  end

  // ==========================================
  // Tests
  initial begin
    rst = 1'b1;
    {awValid, wValid, bReady, arValid, rReady} = 5'h0;
    awAddr = 8'h00;
    arAddr = 8'h00;
    wData = 32'h0;
    wStrb = 4'hf;
    irqPending = 4'h0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdChk(`CRF_ADDR_STACK, 16'h00ff, 16'hffff);
    rdChk(`CRF_ADDR_FLAGS, 16'h0068, 16'hffff);
    rdChk(`CRF_ADDR_PROG, 16'ha53c, 16'hffff);
    // Refused accesses must leave state alone
    axiWr(`CRF_ADDR_FLAGS, 32'h0);
    check({14'h0, resp}, {14'h0, `CRF_RESP_SLVERR});
    rdChk(`CRF_ADDR_FLAGS, 16'h0068, 16'hffff);
    axiRd(8'h40);
    check({14'h0, resp}, {14'h0, `CRF_RESP_SLVERR});
    // Flags not defined by an op are masked out
    alu(crf_pkg::CRF_OP_AND, 8'h00, 8'h00, 8'h6a, 8'hff);
    alu(crf_pkg::CRF_OP_ADD, 8'h08, 8'h08, 8'h68, 8'hff);
    alu(crf_pkg::CRF_OP_ADD, 8'h08, 8'h10, 8'h78, 8'hff);
    alu(crf_pkg::CRF_OP_ADD, 8'h70, 8'h80, 8'hec, 8'hff);
    alu(crf_pkg::CRF_OP_ADD, 8'h80, 8'h00, 8'heb, 8'hff);
    alu(crf_pkg::CRF_OP_ADC, 8'h00, 8'h01, 8'h68, 8'hff);
    alu(crf_pkg::CRF_OP_SUB, 8'h02, 8'hff, 8'h6d, 8'hef);
    alu(crf_pkg::CRF_OP_SHL, 8'h00, 8'hfe, 8'h6d, 8'h6f);
    alu(crf_pkg::CRF_OP_AND, 8'h00, 8'h00, 8'h6b, 8'hef);
    alu(crf_pkg::CRF_OP_ADD, 8'h09, 8'h09, 8'h68, 8'hff);
    alu(crf_pkg::CRF_OP_ADD, 8'h09, 8'h12, 8'h78, 8'hff);
    alu(crf_pkg::CRF_OP_DECADJ, 8'h00, 8'h18, 8'h68, 8'h6f);
    // Upper correction path: result above 99 forces carry
    alu(crf_pkg::CRF_OP_ADD, 8'h90, 8'ha8, 8'h6c, 8'hff);
    alu(crf_pkg::CRF_OP_DECADJ, 8'h00, 8'h08, 8'h69, 8'h6f);
    // Index and stack
    doCmd(crf_pkg::CRF_OP_PULL, 2'b00, 16'h1234);
    rdChk(`CRF_ADDR_INDEX, 16'h1234, 16'hffff);
    doCmd(crf_pkg::CRF_OP_NOP, 2'b00, 16'h0005);
    check(operandAddr, 16'h1239);
    doCmd(crf_pkg::CRF_OP_SPLOW, 2'b00, 16'h0000);
    rdChk(`CRF_ADDR_STACK, 16'h01ff, 16'hffff);
    p0 = pushCount;
    doCmd(crf_pkg::CRF_OP_PUSH, 2'b00, 16'h0000);
    check(16'(pushCount - p0), 16'h0001);
    check({8'h0, lastPush}, 16'h0008);
    rdChk(`CRF_ADDR_STACK, 16'h01fe, 16'hffff);
    doCmd(crf_pkg::CRF_OP_PULL, 2'b10, 16'h00c3);
    rdChk(`CRF_ADDR_STACK, 16'h01ff, 16'hffff);
    rdChk(`CRF_ADDR_INDEX, 16'hc334, 16'hffff);
    // Explicit save of index high, as a handler must do
    doCmd(crf_pkg::CRF_OP_PUSH, 2'b10, 16'h0000);
    check({8'h0, lastPush}, 16'h00c3);
    rdChk(`CRF_ADDR_STACK, 16'h01fe, 16'hffff);
    doCmd(crf_pkg::CRF_OP_NOP, 2'b01, 16'h0010);
    check(operandAddr, 16'h020e);
    // Program counter
    doCmd(crf_pkg::CRF_OP_JUMP, 2'b00, 16'h4000);
    doCmd(crf_pkg::CRF_OP_FETCH, 2'b00, 16'h0000);
    rdChk(`CRF_ADDR_PROG, 16'h4001, 16'hffff);
    check(busAddr, 16'h4001);
    // Interrupts: masked first, then accepted
    irqPending <= 4'b0110;
    q0 = irqCount;
    doCmd(crf_pkg::CRF_OP_IRQ, 2'b00, 16'h8000);
    check(16'(irqCount - q0), 16'h0000);
    doCmd(crf_pkg::CRF_OP_CLRMASK, 2'b00, 16'h0000);
    rdChk(`CRF_ADDR_FLAGS, 16'h0060, 16'h0068);
    doCmd(crf_pkg::CRF_OP_IRQ, 2'b00, 16'h8000);
    check(16'(irqCount - q0), 16'h0001);
    check({14'h0, lastLevel}, 16'h0001);
    check({8'h0, lastPush & 8'h6f}, 16'h0061);
    rdChk(`CRF_ADDR_FLAGS, 16'h0008, 16'h0008);
    rdChk(`CRF_ADDR_PROG, 16'h8000, 16'hffff);
    doCmd(crf_pkg::CRF_OP_IRET, 2'b00, 16'h0000);
    rdChk(`CRF_ADDR_FLAGS, 16'h0060, 16'hffff);
    // Sleep clears the mask and a request wakes the core
    irqPending <= 4'b0000;
    doCmd(crf_pkg::CRF_OP_IRQ, 2'b00, 16'h8000);
    rdChk(`CRF_ADDR_FLAGS, 16'h0008, 16'h0008);
    doCmd(crf_pkg::CRF_OP_SLEEP, 2'b00, 16'h0000);
    check({15'h0, sleeping}, 16'h0001);
    rdChk(`CRF_ADDR_STATUS, 16'h0006, 16'h0007);
    rdChk(`CRF_ADDR_FLAGS, 16'h0000, 16'h0008);
    irqPending <= 4'b1000;
    n = 0;
    while (sleeping === 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check({15'h0, sleeping}, 16'h0000);
    rdChk(`CRF_ADDR_FLAGS, 16'h0000, 16'h0008);
    irqPending <= 4'b0000;
    // Second reset in mid-run restores stack, flag, program counter and sleep presets
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rdChk(`CRF_ADDR_STACK, 16'h00ff, 16'hffff);
    rdChk(`CRF_ADDR_FLAGS, 16'h0068, 16'hffff);
    rdChk(`CRF_ADDR_PROG, 16'ha53c, 16'hffff);
    check({15'h0, sleeping}, 16'h0000);
    give_verdict();
  end
endmodule : tb
